/* File: design/psf_regs.svh */
// constants of the parallel-serial fifo host controller
// assumes a 20 MHz clock and the apb register map below
`ifndef PSF_REGS_SVH
`define PSF_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSF_CLK_NS        50
`define PSF_STB_LOW_NS    60
`define PSF_STB_HIGH_NS   100
`define PSF_CLEAR_NS      100
`define PSF_REPLAY_NS     100
`define PSF_CYC(ns)       ((((ns) + `PSF_CLK_NS - 1) / `PSF_CLK_NS))

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PSF_OFF_CTRL      8'h00
`define PSF_OFF_CMD       8'h04
`define PSF_OFF_WDATA     8'h08
`define PSF_OFF_RDATA     8'h0c
`define PSF_OFF_STATUS    8'h10

// ----------------------------------------------------------------
// control fields and reset
// ----------------------------------------------------------------
`define PSF_CTRL_SER_WR   0
`define PSF_CTRL_SER_RD   1
`define PSF_CTRL_OUT_EN   2
`define PSF_CTRL_MULTI    3
`define PSF_CTRL_FIRST    4
`define PSF_CTRL_WW_LSB   8
`define PSF_CTRL_RW_LSB   12
`define PSF_CTRL_RST      16'h0000

// ----------------------------------------------------------------
// command bits
// ----------------------------------------------------------------
`define PSF_CMD_CLEAR     0
`define PSF_CMD_REPLAY    1
`define PSF_CMD_READ      2

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define PSF_ST_WR_BUSY    8
`define PSF_ST_RD_BUSY    9
`define PSF_ST_RVALID     10
`define PSF_ST_CLR_BUSY   11
`define PSF_ST_WR_REF     12
`define PSF_ST_RD_REF     13

// ----------------------------------------------------------------
// serial word widths
// ----------------------------------------------------------------
`define PSF_WIDTH_MIN     4'h4
`define PSF_WIDTH_MAX     4'h8

`endif

/* File: design/psf_pkg.sv */
// types shared by the fifo host controller files
// assumes nothing beyond a systemverilog compiler
package psf_pkg;

    // strobe sequencer states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_low  = 2'b01,
        st_high = 2'b10
    } psf_stb_e;

    // one fifo word
    typedef logic [8:0] psf_word_t;

endpackage

/* File: design/psf_strobe.sv */
// strobe sequencer: one or more active-low pulses of fixed width
// assumes start only while busy_out is low
module psf_strobe #(
    parameter int LOW_CYC  = 2,
    parameter int HIGH_CYC = 2
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // request
    input  wire logic       start_in,
    input  wire logic [3:0] bits_in,
    // strobe and progress
    output logic            strobe_n_out,
    output logic            busy_out,
    output logic            late_out,
    output logic            rise_out,
    output logic            done_out
);

    psf_pkg::psf_stb_e st;
    psf_pkg::psf_stb_e next_st;
    logic [7:0]        cnt;
    logic [7:0]        next_cnt;
    logic [3:0]        left;
    logic [3:0]        next_left;
    logic              next_strobe_n;
    logic              next_late;
    logic              next_rise;
    logic              next_done;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // low phase, high recovery, repeat until all bits sent
    always_comb begin
        next_st       = st;
        next_cnt      = cnt;
        next_left     = left;
        next_strobe_n = strobe_n_out;
        next_rise     = 1'b0;
        next_done     = 1'b0;
        case (st)
            psf_pkg::st_idle: begin
                if (start_in) begin
                    next_st       = psf_pkg::st_low;
                    next_strobe_n = 1'b0;
                    next_cnt      = 8'(LOW_CYC - 1);
                    next_left     = bits_in;
                end
            end
            psf_pkg::st_low: begin
                if (cnt == 8'h00) begin
                    next_st       = psf_pkg::st_high;
                    next_strobe_n = 1'b1;
                    next_cnt      = 8'(HIGH_CYC - 1);
                    next_left     = left - 4'h1;
                    next_rise     = 1'b1;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            psf_pkg::st_high: begin
                if (cnt != 8'h00) begin
                    next_cnt = cnt - 8'h01;
                end else if (left == 4'h0) begin
                    next_st   = psf_pkg::st_idle;
                    next_done = 1'b1;
                end else begin
                    next_st       = psf_pkg::st_low;
                    next_strobe_n = 1'b0;
                    next_cnt      = 8'(LOW_CYC - 1);
                end
            end
            default: begin
                next_st       = psf_pkg::st_idle;
                next_strobe_n = 1'b1;
            end
        endcase
        next_late = (next_st == psf_pkg::st_low) && (next_cnt == 8'h00);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st           <= psf_pkg::st_idle;
            cnt          <= 8'h00;
            left         <= 4'h0;
            strobe_n_out <= 1'b1;
            busy_out     <= 1'b0;
            late_out     <= 1'b0;
            rise_out     <= 1'b0;
            done_out     <= 1'b0;
        end else begin
            st           <= next_st;
            cnt          <= next_cnt;
            left         <= next_left;
            strobe_n_out <= next_strobe_n;
            busy_out     <= (next_st != psf_pkg::st_idle);
            late_out     <= next_late;
            rise_out     <= next_rise;
            done_out     <= next_done;
        end
    end

endmodule

/* File: design/psf_host.sv */
// host controller for a parallel-serial fifo, driven from apb
// assumes the fifo pins wired straight to the ports, inputs synchronous
//
// What this block does
// - data pin i (4 to 8) tied to write strobe gives i serial clocks per word; widths below 4 give 4.
// - output pin j (4 to 8) tied to read strobe gives j serial clocks per word; widths below 4 give 4.
// - grounded cascade input means single mode; replay pin then retransmits.
// - in chained use only the first-loaded device has replay pin grounded.
`include "psf_regs.svh"

module psf_host #(
    parameter int LOW_CYC    = `PSF_CYC(`PSF_STB_LOW_NS),
    parameter int HIGH_CYC   = `PSF_CYC(`PSF_STB_HIGH_NS),
    parameter int CLEAR_CYC  = `PSF_CYC(`PSF_CLEAR_NS),
    parameter int REPLAY_CYC = `PSF_CYC(`PSF_REPLAY_NS)
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // fifo write side
    output logic             wr_n_out,
    output logic [8:0]       par_in_bus_out,
    output logic             ser_in_out,
    // fifo read side
    output logic             rd_n_out,
    output logic             out_en_n_out,
    input  wire logic [8:0]  par_out_bus_in,
    input  wire logic        ser_out_in,
    // fifo control
    output logic             clear_n_out,
    output logic             first_or_replay_n_out,
    output logic             cascade_in_n_out,
    // fifo flags
    input  wire logic        mem_full_n_in,
    input  wire logic        near_full_n_in,
    input  wire logic        mem_empty_n_in,
    input  wire logic        near_empty_n_in,
    input  wire logic        half_level_n_in,
    input  wire logic        edge_level_n_in
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [15:0]        ctrl;
    logic [15:0]        next_ctrl;
    psf_pkg::psf_word_t wshift;
    psf_pkg::psf_word_t next_wshift;
    psf_pkg::psf_word_t rshift;
    psf_pkg::psf_word_t next_rshift;
    psf_pkg::psf_word_t rdata;
    psf_pkg::psf_word_t next_rdata;
    logic [3:0]         ridx;
    logic [3:0]         next_ridx;
    logic               rvalid;
    logic               next_rvalid;
    logic               wr_ref;
    logic               next_wr_ref;
    logic               rd_ref;
    logic               next_rd_ref;
    logic [7:0]         pcnt;
    logic [7:0]         next_pcnt;
    logic               next_clear_n;
    logic               replay_n;
    logic               next_replay_n;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    logic               acc;
    logic               wr_acc;
    logic               mapped;
    logic               wr_go;
    logic               rd_go;
    logic               clear_go;
    logic               replay_go;
    logic               wr_busy;
    logic               wr_rise;
    logic               rd_busy;
    logic               rd_late;
    logic               rd_done;
    logic [31:0]        status;

    // bits per word: one for parallel, clamped width for serial
    function automatic logic [3:0] sel_bits(input logic ser, input logic [3:0] w);
        if (!ser) begin
            return 4'h1;
        end else if (w < `PSF_WIDTH_MIN) begin
            return `PSF_WIDTH_MIN;
        end else if (w > `PSF_WIDTH_MAX) begin
            return `PSF_WIDTH_MAX;
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // strobe sequencers
    // ----------------------------------------------------------------
    // independent sides
    psf_strobe #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_wr (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .start_in     (wr_go),
        .bits_in      (sel_bits(ctrl[`PSF_CTRL_SER_WR], ctrl[`PSF_CTRL_WW_LSB +: 4])),
        .strobe_n_out (wr_n_out),
        .busy_out     (wr_busy),
        .late_out     (),
        .rise_out     (wr_rise),
        .done_out     ()
    );

    psf_strobe #(.LOW_CYC(LOW_CYC), .HIGH_CYC(HIGH_CYC)) u_rd (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .start_in     (rd_go),
        .bits_in      (sel_bits(ctrl[`PSF_CTRL_SER_RD], ctrl[`PSF_CTRL_RW_LSB +: 4])),
        .strobe_n_out (rd_n_out),
        .busy_out     (rd_busy),
        .late_out     (rd_late),
        .rise_out     (),
        .done_out     (rd_done)
    );

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    // one wait state, then pready
    assign acc    = psel_in & penable_in & pready_out;
    assign wr_acc = acc & pwrite_in;
    assign mapped = (paddr_in == `PSF_OFF_CTRL) || (paddr_in == `PSF_OFF_CMD) ||
                    (paddr_in == `PSF_OFF_WDATA) || (paddr_in == `PSF_OFF_RDATA) ||
                    (paddr_in == `PSF_OFF_STATUS);

    // status word: flags straight from the fifo
    // six flags
    assign status = {18'h00000, rd_ref, wr_ref, ~clear_n_out, rvalid, rd_busy, wr_busy,
                     2'b00, edge_level_n_in, half_level_n_in, near_empty_n_in,
                     mem_empty_n_in, near_full_n_in, mem_full_n_in};

    // no write into a full fifo
    assign wr_go = wr_acc && (paddr_in == `PSF_OFF_WDATA) && !wr_busy &&
                   mem_full_n_in && clear_n_out;
    // no read from an empty fifo
    assign rd_go = wr_acc && (paddr_in == `PSF_OFF_CMD) && pwdata_in[`PSF_CMD_READ] &&
                   !rd_busy && mem_empty_n_in && clear_n_out;
    assign clear_go = wr_acc && (paddr_in == `PSF_OFF_CMD) && pwdata_in[`PSF_CMD_CLEAR] &&
                      (pcnt == 8'h00);
    assign replay_go = wr_acc && (paddr_in == `PSF_OFF_CMD) && pwdata_in[`PSF_CMD_REPLAY] &&
                       (pcnt == 8'h00) && !clear_go && !ctrl[`PSF_CTRL_MULTI];

    // ----------------------------------------------------------------
    // apb answer
    // ----------------------------------------------------------------
    always_comb begin
        next_pready  = psel_in & penable_in & ~pready_out;
        next_pslverr = next_pready & ~mapped;
        next_prdata  = 32'h00000000;
        if (next_pready && !pwrite_in) begin
            case (paddr_in)
                `PSF_OFF_CTRL:   next_prdata = {16'h0000, ctrl};
                `PSF_OFF_RDATA:  next_prdata = {23'h000000, rdata};
                `PSF_OFF_STATUS: next_prdata = status;
                default:         next_prdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // control, data path and flags
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl     = ctrl;
        next_wshift   = wshift;
        next_rshift   = rshift;
        next_rdata    = rdata;
        next_ridx     = ridx;
        next_rvalid   = rvalid;
        next_wr_ref   = wr_ref;
        next_rd_ref   = rd_ref;
        next_pcnt     = pcnt;
        next_clear_n  = clear_n_out;
        next_replay_n = replay_n;
        if (wr_acc && (paddr_in == `PSF_OFF_CTRL)) begin
            next_ctrl = pwdata_in[15:0];
        end
        // sticky refusals, write one to clear, set wins
        if (wr_acc && (paddr_in == `PSF_OFF_STATUS)) begin
            if (pwdata_in[`PSF_ST_WR_REF]) next_wr_ref = 1'b0;
            if (pwdata_in[`PSF_ST_RD_REF]) next_rd_ref = 1'b0;
        end
        if (wr_acc && (paddr_in == `PSF_OFF_WDATA) && !wr_go) next_wr_ref = 1'b1;
        if (wr_acc && (paddr_in == `PSF_OFF_CMD) && pwdata_in[`PSF_CMD_READ] && !rd_go) begin
            next_rd_ref = 1'b1;
        end
        // whole word shifted before the fifo advances
        if (wr_go) begin
            next_wshift = pwdata_in[8:0];
        end else if (wr_rise && ctrl[`PSF_CTRL_SER_WR]) begin
            next_wshift = {1'b0, wshift[8:1]};
        end
        if (rd_go) begin
            next_rshift = 9'h000;
            next_ridx   = 4'h0;
        end else if (rd_late && ctrl[`PSF_CTRL_SER_RD]) begin
            next_rshift[ridx] = ser_out_in;
            next_ridx         = ridx + 4'h1;
        end else if (rd_late) begin
            next_rshift = par_out_bus_in;
        end
        // read data valid until RDATA is read or a clear starts, set wins over the read
        if (!acc || pwrite_in || (paddr_in != `PSF_OFF_RDATA)) begin
            next_rvalid = rvalid;
        end else begin
            next_rvalid = 1'b0;
        end
        if (rd_done) begin
            next_rdata  = rshift;
            next_rvalid = 1'b1;
        end
        // hold clear low for the pulse
        // replay pulse moves only the read position
        if (clear_go) begin
            next_pcnt    = 8'(CLEAR_CYC);
            next_clear_n = 1'b0;
            next_rvalid  = 1'b0;
        end else if (replay_go) begin
            next_pcnt     = 8'(REPLAY_CYC);
            next_replay_n = 1'b0;
        end else if (pcnt == 8'h01) begin
            next_pcnt     = 8'h00;
            next_clear_n  = 1'b1;
            next_replay_n = 1'b1;
        end else if (pcnt != 8'h00) begin
            next_pcnt = pcnt - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl                  <= `PSF_CTRL_RST;
            wshift                <= 9'h000;
            rshift                <= 9'h000;
            rdata                 <= 9'h000;
            ridx                  <= 4'h0;
            rvalid                <= 1'b0;
            wr_ref                <= 1'b0;
            rd_ref                <= 1'b0;
            pcnt                  <= 8'h00;
            clear_n_out           <= 1'b1;
            replay_n              <= 1'b1;
            prdata_out            <= 32'h00000000;
            pready_out            <= 1'b0;
            pslverr_out           <= 1'b0;
            par_in_bus_out        <= 9'h000;
            ser_in_out            <= 1'b0;
            out_en_n_out          <= 1'b1;
            first_or_replay_n_out <= 1'b1;
            cascade_in_n_out      <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            wshift      <= next_wshift;
            rshift      <= next_rshift;
            rdata       <= next_rdata;
            ridx        <= next_ridx;
            rvalid      <= next_rvalid;
            wr_ref      <= next_wr_ref;
            rd_ref      <= next_rd_ref;
            pcnt        <= next_pcnt;
            clear_n_out <= next_clear_n;
            replay_n    <= next_replay_n;
            prdata_out  <= next_prdata;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
            // tied pin left low, serial data on its own pin
            par_in_bus_out <= next_ctrl[`PSF_CTRL_SER_WR] ? 9'h000 : next_wshift;
            ser_in_out     <= next_wshift[0];
            out_en_n_out <= ~next_ctrl[`PSF_CTRL_OUT_EN];
            // first device held low in chained use
            first_or_replay_n_out <= next_ctrl[`PSF_CTRL_MULTI] ?
                                     ~next_ctrl[`PSF_CTRL_FIRST] : next_replay_n;
            // cascade input grounded in single mode
            cascade_in_n_out <= next_ctrl[`PSF_CTRL_MULTI];
        end
    end

endmodule

/* File: verif/psf_fifo_model.sv */
// behavioural fifo device facing the host controller
// assumes host strobes; serial width wiring given by ser_w_in
module psf_fifo_model #(
    parameter int DEPTH = 16  // depth shortened for the run
) (
    // strobes and data from the host
    input  wire logic       wr_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       clear_n_in,
    input  wire logic       replay_n_in,
    input  wire logic       out_en_n_in,
    input  wire logic [8:0] data_in,
    input  wire logic       ser_in,
    // board wiring of the serial width pin
    input  wire logic       ser_mode_in,
    input  wire logic [3:0] ser_w_in,
    // outputs, flags in host status order
    output logic [8:0]      q_out,
    output logic [5:0]      flags_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] mem [DEPTH];
    logic [8:0] q = '0;
    logic [8:0] sh = '0;
    int         wc = 0;
    int         rc = 0;
    int         nb = 0;
    int         occ;
    assign occ = wc - rc;
    always @(negedge clear_n_in) begin
        wc = 0;
        rc = 0;
        nb = 0;
        sh = '0;
    end
    always @(posedge wr_n_in) if (occ < DEPTH) begin
        if (!ser_mode_in) begin
            mem[wc % DEPTH] = data_in;
            wc++;
        end else begin
            sh[nb] = ser_in;
            nb++;
            if (nb == int'(ser_w_in)) begin
                mem[wc % DEPTH] = sh;
                wc++;
                nb = 0;
            end
        end
    end
    // reads, none while empty, no fall-through delay
    always @(negedge rd_n_in) if (occ > 0) begin
        q = mem[rc % DEPTH];
        rc++;
    end
    // replay moves only the read position; full at wrap reads as empty
    always @(negedge replay_n_in) rc = wc - (wc % DEPTH);
    // released outputs show the inverse of the last word
    assign q_out = out_en_n_in ? ~q : q;
    assign flags_out = {!(occ <= DEPTH / 8 || occ >= DEPTH * 7 / 8), occ <= DEPTH / 2,
                        occ > 1, occ > 0, occ < DEPTH - 1, occ < DEPTH};
endmodule

/* File: verif/psf_host_monitor.sv */
// concurrent checks on the host controller ports
// assumes default strobe, clear and replay lengths of two cycles
module psf_host_monitor (
    // clock, reset and apb
    input wire logic        clk_in, rst_b_in, psel_in, penable_in, pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic        pready_out, pslverr_out,
    // fifo pins
    input wire logic        wr_n_out, rd_n_out, out_en_n_out, clear_n_out,
    input wire logic        first_or_replay_n_out, cascade_in_n_out,
    input wire logic [8:0]  par_in_bus_out,
    input wire logic        mem_full_n_in, mem_empty_n_in
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic acc;
    // apb write taking effect
    assign acc = psel_in && penable_in && pready_out && pwrite_in;
    wait_state_a: assert property (psel_in && !penable_in |=> !pready_out ##1 pready_out)
        else $error("apb answer not after one wait state");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    full_block_a: assert property (
        acc && paddr_in == 8'h08 && !mem_full_n_in && wr_n_out |=> wr_n_out)
        else $error("write strobe while full");
    empty_block_a: assert property (
        acc && paddr_in == 8'h04 && pwdata_in[2] && !mem_empty_n_in && rd_n_out |=> rd_n_out)
        else $error("read strobe while empty");
    write_pulse_a: assert property ($fell(wr_n_out) |=> !wr_n_out ##1 wr_n_out ##1 wr_n_out)
        else $error("write strobe shape wrong");
    data_hold_a: assert property (!wr_n_out && !$past(wr_n_out) |-> $stable(par_in_bus_out))
        else $error("write data moved during strobe");
    read_pulse_a: assert property ($fell(rd_n_out) |=> !rd_n_out ##1 rd_n_out)
        else $error("read strobe shape wrong");
    clear_pulse_a: assert property ($fell(clear_n_out) |=> !clear_n_out ##1 clear_n_out)
        else $error("clear pulse length wrong");
    replay_pulse_a: assert property (acc && paddr_in == 8'h04 && pwdata_in[1:0] == 2'b10
        && !cascade_in_n_out && first_or_replay_n_out && clear_n_out
        |=> !first_or_replay_n_out [*2] ##1 first_or_replay_n_out)
        else $error("replay pulse wrong");
    out_enable_a: assert property (acc && paddr_in == 8'h00
        |=> out_en_n_out == !$past(pwdata_in[2])) else $error("output enable wrong");
    cascade_mode_a: assert property (acc && paddr_in == 8'h00
        |=> cascade_in_n_out == $past(pwdata_in[3])) else $error("cascade level wrong");
endmodule
bind psf_host psf_host_monitor u_mon (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pready_out, .pslverr_out, .wr_n_out, .rd_n_out, .out_en_n_out,
    .clear_n_out, .first_or_replay_n_out, .cascade_in_n_out, .par_in_bus_out,
    .mem_full_n_in, .mem_empty_n_in);

/* File: verif/tb.sv */
// self-checking bench: apb master, host controller, fifo model
// assumes the host register map and the model depth below
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 16;
    logic        clk_in = 0, rst_b_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, wr_n, ser_in, rd_n, out_en_n, clear_n, replay_n;
    logic [8:0]  pin, pout;
    logic [5:0]  flags;
    logic        ser_mode = 0;
    int          fail_count = 0, checks = 0;
    initial forever #25 clk_in = ~clk_in;
    psf_host DUT (.clk_in, .rst_b_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .wr_n_out(wr_n), .par_in_bus_out(pin), .ser_in_out(ser_in),
        .rd_n_out(rd_n), .out_en_n_out(out_en_n), .par_out_bus_in(pout), .ser_out_in(1'b0),
        .clear_n_out(clear_n), .first_or_replay_n_out(replay_n), .cascade_in_n_out(),
        .mem_full_n_in(flags[0]), .near_full_n_in(flags[1]), .mem_empty_n_in(flags[2]),
        .near_empty_n_in(flags[3]), .half_level_n_in(flags[4]), .edge_level_n_in(flags[5]));
    psf_fifo_model #(.DEPTH(DEPTH)) u_fifo (.wr_n_in(wr_n), .rd_n_in(rd_n), .clear_n_in(clear_n),
        .replay_n_in(replay_n), .out_en_n_in(out_en_n), .data_in(pin), .ser_in(ser_in),
        .ser_mode_in(ser_mode), .ser_w_in(4'h4), .q_out(pout), .flags_out(flags));
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one apb transfer, held until ready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            $display("mismatch %s expected %h seen %h", s, x, g);
            fail_count++;
        end
    endtask
    // read a register and compare masked bits
    task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, '0, r, e);
        chk(s, x, r & m);
    endtask
    // poll a status bit until it reaches v
    task automatic waitbit(input int b, input logic v);
        logic [31:0] r;
        logic        e;
        for (int n = 0; n < 40; n++) begin
            apb(8'h10, 1'b0, '0, r, e);
            if (r[b] === v) return;
        end
        fail_count++;
        summarize();
    endtask
    function automatic logic [8:0] word(input int i);
        return 9'(i * 37 + 3);
    endfunction
    // read one word from the fifo into RDATA
    task automatic rword(input string s, input logic [8:0] x);
        wr(8'h04, 32'h4);
        waitbit(10, 1'b1);
        rchk(s, 8'h0c, 32'h1ff, {23'h0, x});
    endtask
    initial begin
        logic [31:0] r;
        logic        e;
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rchk("ctrl reset", 8'h00, 32'hffffffff, 32'h0);
        apb(8'h20, 1'b0, '0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        wr(8'h04, 32'h1);
        waitbit(11, 1'b0);
        rchk("flags after clear", 8'h10, 32'h3fff, 32'h13);
        wr(8'h00, 32'h4);
        for (int i = 0; i < DEPTH; i++) begin
            wr(8'h08, {23'h0, word(i)});
            waitbit(8, 1'b0);
            if (i == 0) rchk("flags one word", 8'h10, 32'h3f, 32'h17);
        end
        rchk("flags full", 8'h10, 32'h3fff, 32'h0c);
        wr(8'h08, 32'h1ff);
        rchk("write refused", 8'h10, 32'h1000, 32'h1000);
        $display("test fill done");
        for (int i = 0; i < DEPTH; i++) rword("word order", word(i));
        rchk("flags empty", 8'h10, 32'h3f, 32'h13);
        wr(8'h04, 32'h4);
        rchk("read refused", 8'h10, 32'h2000, 32'h2000);
        $display("test drain done");
        for (int i = 20; i < 23; i++) begin
            wr(8'h08, {23'h0, word(i)});
            waitbit(8, 1'b0);
        end
        rword("before replay", word(20));
        wr(8'h04, 32'h2);
        rchk("still busy free", 8'h10, 32'h300, 32'h0);
        rword("after replay", word(20));
        wr(8'h00, 32'h0);
        rword("outputs released", ~word(21));
        ser_mode <= 1'b1;
        wr(8'h00, 32'h405);
        wr(8'h08, 32'ha5);
        waitbit(8, 1'b0);
        ser_mode <= 1'b0;
        wr(8'h00, 32'h4);
        rword("older word", word(22));
        rword("serial word", 9'h005);
        wr(8'h00, 32'h18);
        rchk("multi", 8'h00, 32'h18, 32'h18);
        $display("test replay and serial done");
        summarize();
    end
endmodule
